// [common/scb_pkg.sv]
package scb_pkg;

    // Register and frame widths
    localparam int DATA_W   = 16;
    localparam int HDR_BITS = 8;
    localparam int ADDR_W   = 5;
    localparam int AXI_AW   = 6;
    localparam int IRQ_W    = 3;

    // Register indexes; AXI byte address is four times the index
    localparam logic [4:0] REG_CTRL  = 5'h00;
    localparam logic [4:0] REG_GOUT  = 5'h01;
    localparam logic [4:0] REG_MIX   = 5'h02;
    localparam logic [4:0] REG_BANK1 = 5'h03;
    localparam logic [4:0] REG_BANK2 = 5'h04;
    localparam logic [4:0] REG_RDBK  = 5'h05;
    localparam logic [4:0] REG_ISTA  = 5'h06;
    localparam logic [4:0] REG_IMASK = 5'h07;

    // Serial interface control register fields
    localparam int CTL_4W      = 0;
    localparam int CTL_SW      = 1;
    localparam int CTL_ADDR    = 2;
    localparam int CTL_EN      = 3;
    localparam int CTL_BANK    = 4;
    localparam int CTL_SWRST   = 5;
    localparam int CTL_RELOCK  = 6;
    localparam int CTL_XGPO    = 7;
    localparam int CTL_LOCKGPO = 8;

    // Interrupt status bits
    localparam int IRQ_CAL    = 0;
    localparam int IRQ_LOCK   = 1;
    localparam int IRQ_UNLOCK = 2;

    // General output pin shared with lock flag and serial data out
    localparam int GPO_SHARED = 3;
    localparam int GPO_W      = 6;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        SER_IDLE = 5'h01,
        SER_HEAD = 5'h02,
        SER_WR   = 5'h04,
        SER_RD   = 5'h08,
        SER_DONE = 5'h10
    } scb_ser_st_t;

    // Raw device pins, all asynchronous to CLK
    typedef struct packed {
        logic       sclk;
        logic       senb_n;
        logic       sdio;
        logic       sdi4;
        logic       chip_en;
        logic       bank_sel;
        logic       rst_n;
        logic       lock;
        logic       cal_done;
        logic [1:0] strap;
    } scb_pin_t;

    // Controls toward the analog core
    typedef struct packed {
        logic              analog_en;
        logic              cal_start;
        logic              bank_sel;
        logic [1:0]        mix;
        logic [DATA_W-1:0] bank_word;
    } scb_ana_t;

endpackage : scb_pkg

// [hw/scb_core.sv]
// Summary of operation
// - Host reads every register serially, writes all but readback
// - Four-wire bit moves data to separate pins
// - Enable rise powers analog, starts calibration
// - Relock bit self-clears, restarts calibration
// - Low reset pin restores startup state
// - Internal power-on reset; unused pin held high
// - Bank-select pin picks active PLL bank
// - Low selects bank one, high bank two
// - Software mode replaces the three control pins
// - Software mode frees two pins as outputs
// - Four devices share bus via strap pins
// - After reset all devices accept every write
// - Address enable makes device match its straps
// - General outputs hold per-path states
// - Mixer bias takes one of four settings
// - Lock status readable, optionally on output
module scb_core (
    // Clock and reset
    input  wire logic                       CLK,
    input  wire logic                       RESET,
    // Device pins
    input  wire scb_pkg::scb_pin_t          PINS,
    output logic                            SDIO_O,
    output logic                            SDIO_OE,
    output logic [scb_pkg::GPO_W-1:0]       GENERAL_OUTPUT,
    output logic [1:0]                      XGPO,
    output logic                            XGPO_OE,
    // Analog core controls
    output scb_pkg::scb_ana_t               ANA,
    // AXI4-Lite write channels
    input  wire logic [scb_pkg::AXI_AW-1:0] AWADDR,
    input  wire logic                       AWVALID,
    output logic                            AWREADY,
    input  wire logic [31:0]                WDATA,
    input  wire logic [3:0]                 WSTRB,
    input  wire logic                       WVALID,
    output logic                            WREADY,
    output logic [1:0]                      BRESP,
    output logic                            BVALID,
    input  wire logic                       BREADY,
    // AXI4-Lite read channels
    input  wire logic [scb_pkg::AXI_AW-1:0] ARADDR,
    input  wire logic                       ARVALID,
    output logic                            ARREADY,
    output logic [31:0]                     RDATA,
    output logic [1:0]                      RRESP,
    output logic                            RVALID,
    input  wire logic                       RREADY,
    // Interrupt
    output logic                            IRQ
);
    import scb_pkg::*;

    typedef struct packed {
        scb_pin_t s1;
        scb_pin_t s2;
        scb_pin_t pv;
    } scb_sync_t;

    typedef struct packed {
        logic              aw_held;
        logic [4:0]        aw_idx;
        logic              w_held;
        logic [DATA_W-1:0] wdata;
        logic [1:0]        wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [DATA_W-1:0] rdata;
    } scb_axi_t;

    typedef struct packed {
        scb_ser_st_t       st;
        logic [4:0]        cnt;
        logic [DATA_W-1:0] shift;
        logic              match;
        logic [4:0]        addr;
        logic              sdo;
        logic              sdio_oe;
    } scb_ser_t;

    typedef struct packed {
        logic [DATA_W-1:0] ctrl;
        logic [DATA_W-1:0] gout;
        logic [1:0]        mix;
        logic [DATA_W-1:0] bank1;
        logic [DATA_W-1:0] bank2;
        logic [IRQ_W-1:0]  ista;
        logic [IRQ_W-1:0]  imask;
        logic              en_q;
        logic              bank_q;
        logic              lock_q;
        logic              cal_busy;
        scb_ana_t          ana;
        logic [GPO_W-1:0]  general_output;
        logic [1:0]        xgpo;
        logic              xgpo_oe;
        logic              irq;
    } scb_core_t;

    typedef struct packed {
        scb_sync_t sy;
        scb_axi_t  ax;
        scb_ser_t  se;
        scb_core_t co;
    } scb_state_t;

    // Idle pin images and an idle frame state out of reset, so that
    // no phantom frame, pin reset or illegal state code follows it
    function automatic scb_state_t rst_val();
        scb_state_t v;
        v = '0;
        v.se.st        = SER_IDLE;
        v.sy.s1.senb_n = 1'b1;
        v.sy.s2.senb_n = 1'b1;
        v.sy.pv.senb_n = 1'b1;
        v.sy.s1.rst_n  = 1'b1;
        v.sy.s2.rst_n  = 1'b1;
        v.sy.pv.rst_n  = 1'b1;
        return v;
    endfunction : rst_val

    localparam scb_state_t ST_RST = rst_val();

    scb_state_t       r;
    scb_state_t       n;
    logic             sclk_rise;
    logic             sclk_fall;
    logic             sw;
    logic             en_eff;
    logic             bank_eff;
    logic             din;
    logic             cal_go;
    logic             dig_rst;
    logic [HDR_BITS-1:0] hdr;
    logic [IRQ_W-1:0] ev;
    logic [7:0]       act;
    logic [GPO_W-1:0] gsel;

    function automatic logic mapped(logic [4:0] idx);
        return idx <= REG_IMASK;
    endfunction : mapped

    function automatic logic [DATA_W-1:0] rd_val(scb_core_t c,
                                                 logic [4:0] idx);
        logic [DATA_W-1:0] v;
        v = '0;
        case (idx)
            REG_CTRL:  v = c.ctrl;
            REG_GOUT:  v = c.gout;
            REG_MIX:   v[1:0] = c.mix;
            REG_BANK1: v = c.bank1;
            REG_BANK2: v = c.bank2;
            REG_RDBK:  v[3:0] = {c.bank_q, c.cal_busy, c.en_q, c.lock_q};
            REG_ISTA:  v[IRQ_W-1:0] = c.ista;
            REG_IMASK: v[IRQ_W-1:0] = c.imask;
            default:   v = '0;
        endcase
        return v;
    endfunction : rd_val

    function automatic scb_core_t reg_wr(scb_core_t c, logic [4:0] idx,
                                         logic [DATA_W-1:0] d,
                                         logic [1:0] be);
        logic [DATA_W-1:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        case (idx)
            REG_CTRL:  c.ctrl = (c.ctrl & ~m) | (d & m);
            REG_GOUT:  c.gout = (c.gout & ~m) | (d & m);
            REG_MIX:   if (be[0]) c.mix = d[1:0];
            REG_BANK1: c.bank1 = (c.bank1 & ~m) | (d & m);
            REG_BANK2: c.bank2 = (c.bank2 & ~m) | (d & m);
            REG_ISTA:  c.ista = c.ista & ~(d[IRQ_W-1:0] & m[IRQ_W-1:0]);
            REG_IMASK: if (be[0]) c.imask = d[IRQ_W-1:0];
            default:   c = c;
        endcase
        return c;
    endfunction : reg_wr

    always_comb begin
        n   = r;
        hdr = '0;
        n.sy.s1 = PINS;
        n.sy.s2 = r.sy.s1;
        n.sy.pv = r.sy.s2;
        sclk_rise = r.sy.s2.sclk & ~r.sy.pv.sclk;
        sclk_fall = ~r.sy.s2.sclk & r.sy.pv.sclk;
        sw       = r.co.ctrl[CTL_SW];
        en_eff   = sw ? r.co.ctrl[CTL_EN] : r.sy.s2.chip_en;
        bank_eff = sw ? r.co.ctrl[CTL_BANK] : r.sy.s2.bank_sel;
        din = r.co.ctrl[CTL_4W] ? r.sy.s2.sdi4 : r.sy.s2.sdio;

        // AXI4-Lite slave: one write and one read at a time
        if (AWVALID && r.ax.awready) begin
            n.ax.aw_held = 1'b1;
            n.ax.aw_idx  = {1'b0, AWADDR[AXI_AW-1:2]};
        end
        if (WVALID && r.ax.wready) begin
            n.ax.w_held = 1'b1;
            n.ax.wdata  = WDATA[DATA_W-1:0];
            n.ax.wstrb  = WSTRB[1:0];
        end
        if (r.ax.bvalid && BREADY)
            n.ax.bvalid = 1'b0;
        if (r.ax.aw_held && r.ax.w_held && !r.ax.bvalid) begin
            n.co = reg_wr(n.co, r.ax.aw_idx, r.ax.wdata, r.ax.wstrb);
            n.ax.aw_held = 1'b0;
            n.ax.w_held  = 1'b0;
            n.ax.bvalid  = 1'b1;
            n.ax.bresp   = mapped(r.ax.aw_idx) ? RESP_OKAY : RESP_SLVERR;
        end
        if (r.ax.rvalid && RREADY)
            n.ax.rvalid = 1'b0;
        if (ARVALID && r.ax.arready) begin
            n.ax.rvalid = 1'b1;
            n.ax.rdata  = rd_val(r.co, {1'b0, ARADDR[AXI_AW-1:2]});
            n.ax.rresp  = mapped({1'b0, ARADDR[AXI_AW-1:2]}) ?
                          RESP_OKAY : RESP_SLVERR;
        end
        n.ax.awready = ~n.ax.aw_held;
        n.ax.wready  = ~n.ax.w_held;
        n.ax.arready = ~n.ax.rvalid;

        // Serial frame: rw, slice[1:0], addr[4:0], then 16 data bits
        if (r.sy.s2.senb_n) begin
            n.se.st      = SER_IDLE;
            n.se.sdio_oe = 1'b0;
        end else begin
            unique case (r.se.st)
                SER_IDLE: begin
                    n.se.st  = SER_HEAD;
                    n.se.cnt = '0;
                end
                SER_HEAD: if (sclk_rise) begin
                    n.se.shift = {r.se.shift[DATA_W-2:0], din};
                    n.se.cnt   = r.se.cnt + 5'h01;
                    if (r.se.cnt == 5'(HDR_BITS - 1)) begin
                        hdr = {r.se.shift[HDR_BITS-2:0], din};
                        n.se.addr = hdr[4:0];
                        n.se.cnt  = '0;
                        n.se.match = ~r.co.ctrl[CTL_ADDR] |
                                     (hdr[6:5] == r.sy.s2.strap);
                        if (hdr[7]) begin
                            n.se.shift = rd_val(r.co, hdr[4:0]);
                            n.se.st    = SER_RD;
                        end else begin
                            n.se.st = SER_WR;
                        end
                    end
                end
                SER_WR: if (sclk_rise) begin
                    n.se.shift = {r.se.shift[DATA_W-2:0], din};
                    n.se.cnt   = r.se.cnt + 5'h01;
                    if (r.se.cnt == 5'(DATA_W - 1)) begin
                        n.se.st = SER_DONE;
                        if (r.se.match)
                            n.co = reg_wr(n.co, r.se.addr,
                                          {r.se.shift[DATA_W-2:0], din},
                                          2'h3);
                    end
                end
                SER_RD: if (sclk_fall) begin
                    if (r.se.cnt == 5'(DATA_W)) begin
                        n.se.st      = SER_DONE;
                        n.se.sdio_oe = 1'b0;
                    end else begin
                        n.se.sdo     = r.se.shift[DATA_W-1];
                        n.se.shift   = {r.se.shift[DATA_W-2:0], 1'b0};
                        n.se.cnt     = r.se.cnt + 5'h01;
                        n.se.sdio_oe = r.se.match &
                                       ~r.co.ctrl[CTL_4W];
                    end
                end
                SER_DONE: n.se.sdio_oe = 1'b0;
            endcase
        end

        // Self-clearing bits act once, then drop
        cal_go  = (en_eff & ~r.co.en_q) | n.co.ctrl[CTL_RELOCK];
        dig_rst = n.co.ctrl[CTL_SWRST] |
                  (~sw & ~r.sy.s2.rst_n);
        n.co.ctrl[CTL_RELOCK] = 1'b0;
        n.co.ctrl[CTL_SWRST]  = 1'b0;

        n.co.en_q     = en_eff;
        n.co.bank_q   = bank_eff;
        n.co.lock_q   = r.sy.s2.lock;
        n.co.cal_busy = cal_go | (r.co.cal_busy & ~r.sy.s2.cal_done);

        // Events set status after write clears, so only a same-cycle digital reset loses a set
        ev = '0;
        ev[IRQ_CAL]    = cal_go;
        ev[IRQ_LOCK]   = r.sy.s2.lock & ~r.co.lock_q;
        ev[IRQ_UNLOCK] = ~r.sy.s2.lock & r.co.lock_q;
        n.co.ista = n.co.ista | ev;

        // Analog controls
        n.co.ana.analog_en = en_eff;
        n.co.ana.cal_start = cal_go;
        n.co.ana.bank_sel  = bank_eff;
        n.co.ana.mix       = n.co.mix;
        n.co.ana.bank_word = bank_eff ? n.co.bank2 : n.co.bank1;

        // General outputs follow the active path
        act  = bank_eff ? n.co.gout[15:8] : n.co.gout[7:0];
        gsel = act[GPO_W-1:0];
        if (n.co.ctrl[CTL_LOCKGPO])
            gsel[GPO_SHARED] = r.sy.s2.lock;
        if (n.co.ctrl[CTL_4W])
            gsel[GPO_SHARED] = n.se.sdo;
        n.co.general_output     = gsel;
        n.co.xgpo    = act[7:6];
        n.co.xgpo_oe = sw & n.co.ctrl[CTL_XGPO];
        n.co.irq     = |(n.co.ista & n.co.imask);

        // Digital reset spares the bus engines so no transfer breaks
        if (dig_rst)
            n.co = ST_RST.co;
    end

    always_ff @(posedge CLK) begin
        if (RESET)
            r <= ST_RST;
        else
            r <= n;
    end

    assign SDIO_O  = r.se.sdo;
    assign SDIO_OE = r.se.sdio_oe;
    assign GENERAL_OUTPUT     = r.co.general_output;
    assign XGPO    = r.co.xgpo;
    assign XGPO_OE = r.co.xgpo_oe;
    assign ANA     = r.co.ana;
    assign AWREADY = r.ax.awready;
    assign WREADY  = r.ax.wready;
    assign BVALID  = r.ax.bvalid;
    assign BRESP   = r.ax.bresp;
    assign ARREADY = r.ax.arready;
    assign RVALID  = r.ax.rvalid;
    assign RRESP   = r.ax.rresp;
    assign RDATA   = {16'h0000, r.ax.rdata};
    assign IRQ     = r.co.irq;

endmodule : scb_core

// [testbench/scb_chk.sv]
module scb_chk (
    // Clock, reset and pins
    input wire logic                      CLK,
    input wire logic                      RESET,
    input wire scb_pkg::scb_pin_t         PINS,
    input wire logic                      SDIO_OE,
    input wire logic [scb_pkg::GPO_W-1:0] GENERAL_OUTPUT,
    input wire scb_pkg::scb_ana_t         ANA,
    input wire logic                      IRQ,
    // Register bus handshakes
    input wire logic                      AWVALID,
    input wire logic                      AWREADY,
    input wire logic                      WVALID,
    input wire logic                      WREADY,
    input wire logic                      BVALID,
    input wire logic                      BREADY,
    input wire logic [1:0]                BRESP,
    input wire logic                      ARVALID,
    input wire logic                      ARREADY,
    input wire logic                      RVALID,
    input wire logic                      RREADY,
    input wire logic [31:0]               RDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence s_wtake;
        AWVALID && AWREADY && WVALID && WREADY;
    endsequence
    // Frame enable seen high long enough to pass the synchronisers
    sequence s_idle;
        PINS.senb_n [*6];
    endsequence
    property p_b_after; s_wtake |-> ##[1:2] BVALID; endproperty
    a_b_after: assert property (p_b_after)
        else $error("write response late");
    property p_b_hold; BVALID && !BREADY |=> BVALID && $stable(BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");
    property p_aw_low; AWVALID && AWREADY |=> !AWREADY; endproperty
    a_aw_low: assert property (p_aw_low)
        else $error("second address taken");
    property p_r_after; ARVALID && ARREADY |=> RVALID && !ARREADY;
    endproperty
    a_r_after: assert property (p_r_after)
        else $error("read data late");
    property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped");
    property p_rdata_hi; RVALID |-> RDATA[31:16] == 16'h0000; endproperty
    a_rdata_hi: assert property (p_rdata_hi)
        else $error("upper read half not zero");
    property p_cal_pulse; ANA.cal_start |=> !ANA.cal_start; endproperty
    a_cal_pulse: assert property (p_cal_pulse)
        else $error("calibration start too long");
    property p_enable_cal;
        $rose(ANA.analog_en) |-> ##[0:2] ANA.cal_start;
    endproperty
    a_enable_cal: assert property (p_enable_cal)
        else $error("enable without calibration");
    property p_oe_idle; s_idle |-> !SDIO_OE; endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("data driven outside frame");
    property p_por;
        $fell(RESET) |-> !IRQ && !BVALID && ANA == '0 && GENERAL_OUTPUT == '0;
    endproperty
    a_por: assert property (p_por)
        else $error("outputs not cleared by reset");
endmodule : scb_chk

// [testbench/scb_host.sv]
module scb_host (
    // Clock and device side
    input  wire logic clk,
    input  wire logic sdio_o,
    input  wire logic sdio_oe,
    input  wire logic dout4,
    // Bus lines
    output logic      sclk,
    output logic      senb_n,
    output logic      sdio,
    output logic      sdi4
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv_r;
    logic bit_r;
    logic m4_r;
    // Released line shows the inverse, so a stale bit never passes
    assign sdio = sdio_oe ? sdio_o : (drv_r && !m4_r) ? bit_r : !bit_r;
    assign sdi4 = (drv_r && m4_r) ? bit_r : !bit_r;
    initial begin
        sclk = 1'b0;
        senb_n = 1'b1;
        drv_r = 1'b1;
        bit_r = 1'b0;
        m4_r = 1'b0;
    end
    // Halves of five cycles outlast the two-stage synchroniser
    task automatic xfer(input logic m4, input logic [7:0] hd,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [23:0] sh;
        sh = {hd, wd};
        rd = 16'h0000;
        m4_r <= m4;
        senb_n <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            if (i >= 8 && hd[7]) drv_r <= 1'b0;
            else bit_r <= sh[23-i];
            repeat (5) @(posedge clk);
            sclk <= 1'b1;
            if (i >= 8) rd[23-i] = m4 ? dout4 : sdio;
            repeat (5) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (5) @(posedge clk);
        senb_n <= 1'b1;
        drv_r <= 1'b1;
        repeat (5) @(posedge clk);
    endtask : xfer
endmodule : scb_host

// [testbench/tb.sv]
module tb;
    import scb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK, RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, SDIO_O;
    logic        SDIO_OE, XGPO_OE, en, bsel, rstn, lock, cald;
    logic        h_sclk, h_senb, h_sdio, h_sdi4;
    logic [1:0]  BRESP, RRESP, XGPO, strap;
    logic [3:0]  WSTRB;
    logic [5:0]  AWADDR, ARADDR, GENERAL_OUTPUT;
    logic [15:0] rv, x, z;
    logic [31:0] WDATA, RDATA;
    logic [15:0] mem [8];
    scb_ana_t    ANA;
    scb_pin_t    pins;
    int          fails, num_checks;
    localparam logic [15:0] MSK [8] = '{16'h019F, 16'hFFFF, 16'h0003,
        16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h0007};
    localparam logic [4:0] WR_IDX [4] = '{5'h01, 5'h03, 5'h04, 5'h07};
    assign pins = {h_sclk, h_senb, h_sdio, h_sdi4, en, bsel, rstn, lock,
                   cald, strap};
    scb_core i_dut (.CLK(CLK), .RESET(RESET), .PINS(pins), .SDIO_O(SDIO_O),
        .SDIO_OE(SDIO_OE), .GENERAL_OUTPUT(GENERAL_OUTPUT), .XGPO(XGPO), .XGPO_OE(XGPO_OE),
        .ANA(ANA), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .IRQ(IRQ));
    scb_host i_host (.clk(CLK), .sdio_o(SDIO_O), .sdio_oe(SDIO_OE),
        .dout4(GENERAL_OUTPUT[GPO_SHARED]), .sclk(h_sclk), .senb_n(h_senb),
        .sdio(h_sdio), .sdi4(h_sdi4));
    task automatic chk(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(posedge CLK);
    endtask : tk
    task automatic wg(input logic [4:0] i, input logic [15:0] d);
        logic        aw;
        logic        w;
        logic [15:0] m;
        aw = 1'b1;
        w = 1'b1;
        AWADDR <= {i[3:0], 2'b00};
        WDATA <= {16'h0000, d};
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        while (aw || w) begin
            @(posedge CLK);
            aw = aw && !AWREADY;
            w = w && !WREADY;
            AWVALID <= aw;
            WVALID <= w;
        end
        while (!BVALID) @(posedge CLK);
        // Late ready makes the slave hold its response for a cycle
        BREADY <= 1'b1;
        @(posedge CLK);
        BREADY <= 1'b0;
        chk("bresp", BRESP, i > 7 ? RESP_SLVERR : RESP_OKAY);
        m = {{8{WSTRB[1]}}, {8{WSTRB[0]}}};
        if (i == 6) mem[6] &= ~(d & m);
        else if (i < 8) mem[i] = (mem[i] & ~m) | (d & m & MSK[i]);
        @(posedge CLK);
    endtask : wg
    task automatic rg(input logic [4:0] i, input logic [15:0] e);
        ARADDR <= {i[3:0], 2'b00};
        ARVALID <= 1'b1;
        do @(posedge CLK); while (!ARREADY);
        ARVALID <= 1'b0;
        do @(posedge CLK); while (!RVALID);
        RREADY <= 1'b1;
        @(posedge CLK);
        RREADY <= 1'b0;
        chk("rresp", RRESP, i > 7 ? RESP_SLVERR : RESP_OKAY);
        chk("rdata", RDATA, {16'h0000, e});
        @(posedge CLK);
    endtask : rg
    task automatic final_report;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    // Whole sequence needs about 1800 cycles
    initial begin
        tk(60000);
        fails++;
        final_report();
    end
    initial begin
        {RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h20;
        {en, bsel, lock, cald, strap} = 6'h00;
        rstn = 1'b1;
        {AWADDR, ARADDR, WDATA, WSTRB} = {44'h0, 4'hF};
        mem = '{default: 16'h0000};
        fails = 0;
        num_checks = 0;
        void'($urandom(35));
        tk(5);
        RESET <= 1'b0;
        cald <= 1'b1;
        tk(3);
        for (int i = 0; i < 9; i++) rg(i[4:0], 16'h0000);
        wg(5'h08, 16'h1234);
        foreach (WR_IDX[k]) begin
            wg(WR_IDX[k], 16'($urandom));
            rg(WR_IDX[k], mem[WR_IDX[k]]);
        end
        WSTRB <= 4'h2;
        wg(REG_GOUT, 16'($urandom));
        rg(REG_GOUT, mem[1]);
        WSTRB <= 4'hF;
        for (int k = 0; k < 4; k++) begin
            wg(REG_MIX, 16'(k));
            chk("mix", ANA.mix, mem[2]);
        end
        for (int b = 0; b < 2; b++) begin
            bsel <= b[0];
            tk(6);
            chk("bank", ANA.bank_sel, b[0]);
            chk("word", ANA.bank_word, mem[3+b]);
            chk("gpo", GENERAL_OUTPUT, 6'(mem[1] >> (8 * b)));
        end
        bsel <= 1'b0;
        wg(REG_IMASK, 16'h0001);
        en <= 1'b1;
        tk(8);
        chk("ana_en", ANA.analog_en, 1'b1);
        chk("irq", IRQ, 1'b1);
        wg(REG_ISTA, 16'h0001);
        tk(2);
        chk("irq_clr", IRQ, 1'b0);
        wg(REG_IMASK, 16'h0000);
        wg(REG_CTRL, 16'h0040);
        tk(4);
        rg(REG_ISTA, 16'h0001);
        chk("irq_mask", IRQ, 1'b0);
        rg(REG_CTRL, 16'h0000);
        wg(REG_ISTA, 16'h0007);
        lock <= 1'b1;
        tk(6);
        rg(REG_RDBK, 16'h0003);
        rg(REG_ISTA, 16'h0002);
        wg(REG_CTRL, 16'h0100);
        tk(2);
        chk("lock_gpo", GENERAL_OUTPUT[GPO_SHARED], 1'b1);
        wg(REG_CTRL, 16'h0000);
        strap <= 2'b10;
        x = 16'($urandom);
        z = 16'($urandom);
        i_host.xfer(1'b0, {3'b001, REG_BANK1}, x, rv);
        rg(REG_BANK1, x);
        wg(REG_CTRL, 16'h0004);
        i_host.xfer(1'b0, {3'b001, REG_BANK1}, z, rv);
        rg(REG_BANK1, x);
        i_host.xfer(1'b0, {3'b010, REG_BANK2}, z, rv);
        rg(REG_BANK2, z);
        i_host.xfer(1'b0, {3'b110, REG_BANK1}, 16'h0000, rv);
        chk("ser_rd", rv, x);
        wg(REG_CTRL, 16'h0005);
        i_host.xfer(1'b1, {3'b110, REG_BANK2}, 16'h0000, rv);
        chk("ser_rd4", rv, z);
        i_host.xfer(1'b1, {3'b010, REG_BANK1}, ~x, rv);
        rg(REG_BANK1, ~x);
        lock <= 1'b0;
        tk(6);
        rg(REG_ISTA, 16'h0006);
        wg(REG_CTRL, 16'h0045);
        tk(2);
        rg(REG_ISTA, 16'h0007);
        en <= 1'b0;
        wg(REG_CTRL, 16'h009A);
        tk(3);
        chk("sw_en", ANA.analog_en, 1'b1);
        chk("sw_bank", ANA.bank_sel, 1'b1);
        chk("xgpo_oe", XGPO_OE, 1'b1);
        chk("xgpo", XGPO, mem[1][15:14]);
        wg(REG_CTRL, 16'h00BA);
        tk(4);
        mem = '{default: 16'h0000};
        for (int i = 0; i < 8; i++) rg(i[4:0], mem[i]);
        wg(REG_GOUT, 16'h00FF);
        rstn <= 1'b0;
        tk(8);
        rstn <= 1'b1;
        tk(4);
        rg(REG_GOUT, 16'h0000);
        chk("gpo_rst", GENERAL_OUTPUT, 6'h00);
        final_report();
    end
endmodule : tb
bind scb_core scb_chk i_chk (.CLK(CLK), .RESET(RESET), .PINS(PINS),
    .SDIO_OE(SDIO_OE), .GENERAL_OUTPUT(GENERAL_OUTPUT), .ANA(ANA), .IRQ(IRQ), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
    .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA));
